/* File: bench/bdc_config_bank_props.sv */
/* Checker for the configuration bank ports.
   Assumes it is bound into bdc_config_bank. */
`timescale 1ns/1ns
module bdc_config_bank_props #(parameter MS_CYCLES = 100000) (
  input wire        clk_sys,
  input wire        rst,
  input wire        spi_sclk,
  input wire        spi_cs_n,
  input wire        spi_sdi,
  input wire        spi_sdo,
  input wire        spi_sdo_oe,
  input wire [16:0] pwm_period_ns,
  input wire        pwm_alignment_select,
  input wire        dither_active,
  input wire [3:0]  dither_step_index,
  input wire [7:0]  sense_gain_x10,
  input wire [11:0] dead_time_ns,
  input wire [6:0]  turn_on_ma_first,
  input wire [6:0]  turn_on_ma_second,
  input wire [6:0]  turn_off_ma_first,
  input wire [6:0]  turn_off_ma_second,
  input wire [3:0]  switch_mode,
  input wire [9:0]  turn_on_slew_ns,
  input wire [9:0]  turn_off_slew_ns,
  input wire [12:0] limit_blank_ns,
  input wire [11:0] limit_threshold_mv16,
  input wire [11:0] drain_fault_mv,
  input wire        drain_qualifier_mode,
  input wire [11:0] drain_qualify_ns,
  input wire        frame_reject
);
  // Outputs show stored values from the first edge after reset
  logic [1:0] age;
  always @(posedge clk_sys) begin
    if (rst) age <= 2'd0;
    else if (age != 2'd3) age <= age + 2'd1;
  end
  wire        up   = (age == 2'd3);
  wire [16:0] base = pwm_alignment_select ? 17'd20050 : 17'd20100;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_sel_fall; $fell(spi_cs_n) ##1 !spi_cs_n [*4]; endsequence
  sequence s_sel_idle; spi_cs_n [*5]; endsequence
  AST_OE_ON: assert property (s_sel_fall |-> spi_sdo_oe)
    else $error("sdo enable late");
  AST_OE_OFF: assert property (s_sel_idle |-> !spi_sdo_oe)
    else $error("sdo enable while idle");
  AST_DEAD: assert property (up |-> dead_time_ns >= 100 && dead_time_ns <= 3150
    && dead_time_ns % 50 == 0) else $error("dead time off grid");
  AST_GAIN: assert property (up |-> sense_gain_x10 inside {25, 50, 100, 200})
    else $error("gain value");
  AST_SLEW: assert property (up |-> turn_on_slew_ns <= 750 && turn_on_slew_ns % 50 == 0
    && turn_off_slew_ns <= 750 && turn_off_slew_ns % 50 == 0) else $error("slew");
  AST_BLANK: assert property (up |-> limit_blank_ns >= 1000 && limit_blank_ns <= 6600
    && limit_blank_ns % 200 == 0) else $error("blank time");
  AST_LIMIT: assert property (up |-> limit_threshold_mv16 % 25 == 0
    && limit_threshold_mv16 >= 25 && limit_threshold_mv16 <= 3200) else $error("limit");
  AST_SWITCH: assert property (up |-> switch_mode == {turn_on_ma_first == 0,
    turn_on_ma_second == 0, turn_off_ma_first == 0, turn_off_ma_second == 0})
    else $error("switch mode flags");
  AST_STEP: assert property (up && $changed(dither_step_index) |-> dither_step_index == 0
    || dither_step_index == $past(dither_step_index) + 1) else $error("step order");
  AST_FIXED: assert property ((up && !dither_active) [*2] ##0 $stable(pwm_alignment_select)
    |-> dither_step_index == 0 && pwm_period_ns >= base && pwm_period_ns <= base + 50400
    && (pwm_period_ns - base) % 800 == 0) else $error("fixed period");
endmodule // bdc_config_bank_props

bind bdc_config_bank bdc_config_bank_props #(.MS_CYCLES(MS_CYCLES)) props_inst (.*);

/* File: bench/bdc_host_model.sv */
/* Host model: sends serial frames and samples the readback.
   Assumes one system clock; serial phases last five clocks. */
`timescale 1ns/1ns
module bdc_host_model (
  input  wire  clk_sys,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_sdi,
  input  wire  spi_sdo
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi  = 1'b0;
  end
  // Sends the top nb bits, msb first; fewer than 16 makes a short frame
  task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] r);
    int k;
    r = 16'h0000;
    @(posedge clk_sys);
    #1 spi_cs_n = 1'b0;
    spi_sdi = w[15];
    for (k = 0; k < nb; k++) begin
      repeat (5) @(posedge clk_sys);
      #1 spi_sclk = 1'b1;
      r = {r[14:0], spi_sdo};
      repeat (5) @(posedge clk_sys);
      #1 spi_sclk = 1'b0;
      spi_sdi = (k < 15) ? w[4'(14 - k)] : ~spi_sdi;
    end
    repeat (5) @(posedge clk_sys);
    #1 spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi; // Released line keeps no stale value
  endtask
endmodule // bdc_host_model

/* File: bench/tb_bdc_config_bank.sv */
/* Testbench: resets, writes, readback, refused frames and dither sweep.
   Assumes the host model drives the serial pins. */
`timescale 1ns/1ns
module tb_bdc_config_bank;
  localparam MS = 10; // Short dwell unit keeps the run brief
  logic        clk_sys = 1'b0, rst = 1'b1;
  logic        spi_sclk, spi_cs_n, spi_sdi, spi_sdo, spi_sdo_oe, frame_reject;
  logic        pwm_alignment_select, dither_active, drain_qualifier_mode;
  logic [16:0] pwm_period_ns;
  logic [3:0]  dither_step_index, switch_mode;
  logic [7:0]  sense_gain_x10;
  logic [11:0] dead_time_ns, limit_threshold_mv16, drain_fault_mv, drain_qualify_ns;
  logic [6:0]  turn_on_ma_first, turn_on_ma_second, turn_off_ma_first, turn_off_ma_second;
  logic [9:0]  turn_on_slew_ns, turn_off_slew_ns;
  logic [12:0] limit_blank_ns;
  logic [15:0] rx;
  logic [5:0]  t;
  logic [4:0]  c;
  int          n_mismatch = 0, total_checks = 0, cyc = 0, i, n;
  int          dw[4] = '{1, 2, 5, 10};
  bdc_config_bank #(.MS_CYCLES(MS)) bdc_config_bank_inst (.*);
  bdc_host_model bdc_host_model_inst (.clk_sys(clk_sys), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));
  always #5 clk_sys = ~clk_sys;
  task automatic wrap_up;
    if (n_mismatch == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic frame(input logic [4:0] a, input logic w, input logic [8:0] d,
                       input int nb, input logic bad);
    logic [15:0] f;
    f = {a, w, d, 1'b0};
    f[0] = ~^f[15:1] ^ bad;
    bdc_host_model_inst.xfer(f, nb, rx);
    repeat (8) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [8:0] d);
    frame(a, 1'b1, d, 16, 1'b0);
  endtask
  task automatic wait_step(output int k);
    logic [3:0] p;
    p = dither_step_index;
    k = 0;
    while (dither_step_index === p && k < 2000) begin
      @(posedge clk_sys);
      #1 k++;
    end
    chk("step", (p == 4'd2) ? 4'd0 : p + 4'd1, dither_step_index);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 chk("period", 50500, pwm_period_ns);
    chk("gain", 25, sense_gain_x10);
    chk("dead", 1600, dead_time_ns);
    chk("blank", 1800, limit_blank_ns);
    chk("limit", 3200, limit_threshold_mv16);
    chk("qualify", 3150, drain_qualify_ns);
    chk("switch", 4'hf, switch_mode);
    for (i = 0; i < 4; i++) begin
      wr(5'h00, {2'b00, i[1], {6{i[0]}}});
      chk("period", (i[1] ? 20050 : 20100) + (i[0] ? 50400 : 0), pwm_period_ns);
    end
    for (i = 0; i < 5; i++) begin
      t = (i == 4) ? 6'd63 : 6'(i);
      wr(5'h02, {1'b0, i[1:0], t});
      chk("dead", (t < 3) ? 100 : t * 50, dead_time_ns);
      chk("gain", 8'd25 << i[1:0], sense_gain_x10);
    end
    frame(5'h02, 1'b0, 9'h000, 16, 1'b0);
    frame(5'h02, 1'b0, 9'h000, 16, 1'b0);
    chk("readback", 16'h107e, rx);
    wr(5'h03, 9'h0f0);
    wr(5'h04, 9'h008);
    wr(5'h05, 9'h0f6);
    chk("on1", 75, turn_on_ma_first);
    chk("off2", 40, turn_off_ma_second);
    chk("switch", 4'b0110, switch_mode);
    chk("slew", 750, turn_on_slew_ns);
    chk("slew", 300, turn_off_slew_ns);
    for (i = 0; i < 4; i++) begin
      c = (i == 0) ? 5'd0 : (i == 3) ? 5'd31 : 5'(i + 2);
      wr(5'h06, {c, c[3:0]});
      wr(5'h07, {i[1:0], 2'b00, c});
      chk("blank", (c < 4) ? 1000 : (c + 2) * 200, limit_blank_ns);
      chk("limit", (200 >> i) * (c[3:0] + 1), limit_threshold_mv16);
      chk("drain", c * 50, drain_fault_mv);
    end
    wr(5'h08, 9'h08c);
    chk("qmode", 1, drain_qualifier_mode);
    chk("qualify", 600, drain_qualify_ns);
    frame(5'h00, 1'b1, 9'h03f, 16, 1'b1);
    chk("reject", 1, frame_reject);
    frame(5'h00, 1'b1, 9'h03f, 15, 1'b0);
    chk("reject", 1, frame_reject);
    frame(5'h0b, 1'b1, 9'h03f, 16, 1'b0);
    chk("reject", 1, frame_reject);
    chk("period", 70450, pwm_period_ns);
    wr(5'h00, 9'h000);
    chk("reject", 0, frame_reject);
    for (i = 0; i < 4; i++) begin
      wr(5'h01, {3'd5, i[1:0], 4'd2});
      chk("active", 1, dither_active);
      wait_step(n);
      wait_step(n);
      wait_step(n);
      chk("dwell", MS * dw[i], n);
      @(posedge clk_sys);
      #1 chk("period", 20100 - dither_step_index * 1200, pwm_period_ns);
    end
    wr(5'h01, 9'h000);
    chk("active", 0, dither_active);
    chk("period", 20100, pwm_period_ns);
    wrap_up();
  end
endmodule // tb_bdc_config_bank

/* File: hw/bdc_config_bank.v */
/*
  Serially programmed configuration bank of a three-phase bridge driver.
  Takes 16-bit frames on an SPI-style port (mode 0, msb first, select low),
  stores eleven 9-bit registers and turns their fields into timing and
  threshold values, including the PWM period dither sweep.
  Assumes the host keeps select high between frames and holds sclk low idle.
*/
// Contract
// - PWM period is 20.10 us or 20.05 us plus 0.8 us per period count.
// - Each dither step shortens period by 0.2 us plus 0.2 us per count.
// - Dwell per dither step is 1, 2, 5 or 10 ms by two-bit code.
// - Dither step index runs from 0 up to the four-bit step count, at most 15.
// - Step count zero disables dither; period stays fixed.
// - Sense gain is 2.5, 5, 10 or 20 by two-bit code.
// - Dead-time codes 0 to 2 give the 100 ns minimum.
// - Turn-on current is 5 mA per count; code zero means switch mode.
// - Turn-off current is 5 mA per count to 75 mA; zero means switch mode.
// - Turn-on and turn-off slew times are 50 ns per count, 0 to 750 ns.
// - Blanking time is (code plus two) times 200 ns, up to 6.6 us.
// - Blanking codes 0 to 3 give 1 us.
// - Current limit is maximum threshold times (code+1)/16; default full scale.
// - Maximum threshold is 200, 100, 50 or 25 mV by two-bit code.
// - Drain-source threshold is 50 mV per count, 0 to 3.15 V.
// - Qualifier bit 0 selects debounce, 1 selects blanking.
// - Drain-source qualify time is 50 ns per count, up to 3.15 us.
// - Alignment bit 0 is centre-aligned, 1 edge-aligned; selects period offset.
`timescale 1ns/1ns
`include "bdc_defs.vh"

module bdc_config_bank #(
  parameter MS_CYCLES = `BDC_MS_NS / `BDC_CLK_NS
) (
  input  wire        clk_sys,
  input  wire        rst,
  input  wire        spi_sclk,
  input  wire        spi_cs_n,
  input  wire        spi_sdi,
  output reg         spi_sdo,
  output reg         spi_sdo_oe,
  output reg  [16:0] pwm_period_ns,
  output reg         pwm_alignment_select,
  output reg         dither_active,
  output reg  [3:0]  dither_step_index,
  output reg  [7:0]  sense_gain_x10,
  output reg  [11:0] dead_time_ns,
  output reg  [6:0]  turn_on_ma_first,
  output reg  [6:0]  turn_on_ma_second,
  output reg  [6:0]  turn_off_ma_first,
  output reg  [6:0]  turn_off_ma_second,
  output reg  [3:0]  switch_mode,
  output reg  [9:0]  turn_on_slew_ns,
  output reg  [9:0]  turn_off_slew_ns,
  output reg  [12:0] limit_blank_ns,
  output reg  [11:0] limit_threshold_mv16,
  output reg  [11:0] drain_fault_mv,
  output reg         drain_qualifier_mode,
  output reg  [11:0] drain_qualify_ns,
  output reg         frame_reject
);

  localparam NREG = 11;

  // Dwell lengths in clock cycles
  localparam [23:0] DWELL_1MS  = MS_CYCLES;
  localparam [23:0] DWELL_2MS  = MS_CYCLES * 2;
  localparam [23:0] DWELL_5MS  = MS_CYCLES * 5;
  localparam [23:0] DWELL_10MS = MS_CYCLES * 10;

  function [8:0] reset_of;
    input integer idx;
    begin
      case (idx)
        `BDC_ADDR_PWM_BASE: reset_of = `BDC_RST_PWM_BASE;
        `BDC_ADDR_BRIDGE:   reset_of = `BDC_RST_BRIDGE;
        `BDC_ADDR_LIMIT:    reset_of = `BDC_RST_LIMIT;
        `BDC_ADDR_DRAIN_TH: reset_of = `BDC_RST_DRAIN_TH;
        `BDC_ADDR_DRAIN_Q:  reset_of = `BDC_RST_DRAIN_Q;
        default:            reset_of = `BDC_RST_ZERO;
      endcase
    end
  endfunction

  // Pin synchronisers; stage 0 feeds stage 1 only
  reg [1:0]  sclk_s;
  reg [1:0]  cs_s;
  reg [1:0]  sdi_s;
  reg        sclk_q;
  reg        cs_act_q;
  reg [15:0] rx;
  reg [15:0] tx;
  reg [4:0]  bit_cnt;
  reg [4:0]  rd_addr;

  always @(posedge clk_sys) begin
    if (rst) begin
      sclk_s <= 2'h0;
      cs_s   <= 2'h3;
      sdi_s  <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[0], spi_sclk};
      cs_s   <= {cs_s[0], spi_cs_n};
      sdi_s  <= {sdi_s[0], spi_sdi};
    end
  end

  wire cs_act    = ~cs_s[1];
  wire cs_fall   = cs_act & ~cs_act_q;
  wire cs_rise   = ~cs_act & cs_act_q;
  wire sclk_rise = sclk_s[1] & ~sclk_q;
  wire sclk_fall = ~sclk_s[1] & sclk_q;

  // Odd parity over the whole frame; short frames are dropped, long ones keep their last 16 bits
  wire frame_ok = cs_rise && (bit_cnt == `BDC_FRAME_BITS) && (^rx)
                  && (rx[`BDC_ADDR_MSB:`BDC_ADDR_LSB] <= `BDC_ADDR_LAST);
  wire wr_stb   = frame_ok & rx[`BDC_WR_BIT];

  wire [NREG*9-1:0] cfg_flat;
  wire [8:0]        rd_data  = cfg_flat[rd_addr*9 +: 9];
  wire [14:0]       rd_body  = {rd_addr, 1'b0, rd_data};
  wire [15:0]       rd_frame = {rd_body, ~(^rd_body)};

  always @(posedge clk_sys) begin
    if (rst) begin
      sclk_q       <= 1'b0;
      cs_act_q     <= 1'b0;
      rx           <= 16'h0000;
      tx           <= 16'h0000;
      bit_cnt      <= 5'h00;
      rd_addr      <= 5'h00;
      spi_sdo      <= 1'b0;
      spi_sdo_oe   <= 1'b0;
      frame_reject <= 1'b0;
    end else begin
      sclk_q     <= sclk_s[1];
      cs_act_q   <= cs_act;
      spi_sdo_oe <= cs_act;
      if (cs_fall) begin
        bit_cnt <= 5'h00;
        tx      <= rd_frame;
        spi_sdo <= rd_frame[15];
      end else if (cs_act) begin
        if (sclk_rise) begin
          rx <= {rx[14:0], sdi_s[1]};
          if (bit_cnt != `BDC_FRAME_BITS)
            bit_cnt <= bit_cnt + 5'h01;
        end
        if (sclk_fall) begin
          tx      <= {tx[14:0], 1'b0};
          spi_sdo <= tx[14];
        end
      end
      // Next frame returns the last addressed register
      if (frame_ok)
        rd_addr <= rx[`BDC_ADDR_MSB:`BDC_ADDR_LSB];
      if (cs_rise)
        frame_reject <= ~frame_ok;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi = gi + 1) begin : g_reg
      reg [8:0] word;
      always @(posedge clk_sys) begin
        if (rst)
          word <= reset_of(gi);
        else if (wr_stb && (rx[`BDC_ADDR_MSB:`BDC_ADDR_LSB] == gi))
          word <= rx[`BDC_DATA_MSB:`BDC_DATA_LSB];
      end
      assign cfg_flat[gi*9 +: 9] = word;
    end
  endgenerate

  wire [8:0] r_base  = cfg_flat[`BDC_ADDR_PWM_BASE*9 +: 9];
  wire [8:0] r_dith  = cfg_flat[`BDC_ADDR_DITHER*9 +: 9];
  wire [8:0] r_brg   = cfg_flat[`BDC_ADDR_BRIDGE*9 +: 9];
  wire [8:0] r_on    = cfg_flat[`BDC_ADDR_TURN_ON*9 +: 9];
  wire [8:0] r_off   = cfg_flat[`BDC_ADDR_TURN_OFF*9 +: 9];
  wire [8:0] r_slew  = cfg_flat[`BDC_ADDR_SLEW*9 +: 9];
  wire [8:0] r_lim   = cfg_flat[`BDC_ADDR_LIMIT*9 +: 9];
  wire [8:0] r_dth   = cfg_flat[`BDC_ADDR_DRAIN_TH*9 +: 9];
  wire [8:0] r_dq    = cfg_flat[`BDC_ADDR_DRAIN_Q*9 +: 9];

  wire [5:0] pwm_period_code    = r_base[5:0];
  wire       align_sel          = r_base[`BDC_ALIGN_BIT];
  wire [2:0] dither_step_size   = r_dith[`BDC_DP_MSB:`BDC_DP_LSB];
  wire [1:0] dither_dwell_select = r_dith[`BDC_DD_MSB:`BDC_DD_LSB];
  wire [3:0] dither_step_count  = r_dith[3:0];
  wire [1:0] sense_gain_select  = r_brg[`BDC_SA_MSB:`BDC_SA_LSB];
  wire [5:0] dead_time_code     = r_brg[5:0];
  wire [3:0] on_first           = r_on[`BDC_HI4_MSB:`BDC_HI4_LSB];
  wire [3:0] on_second          = r_on[3:0];
  wire [3:0] off_first          = r_off[`BDC_HI4_MSB:`BDC_HI4_LSB];
  wire [3:0] off_second         = r_off[3:0];
  wire [3:0] on_slew            = r_slew[`BDC_HI4_MSB:`BDC_HI4_LSB];
  wire [3:0] off_slew           = r_slew[3:0];
  wire [4:0] limit_blank_code   = r_lim[`BDC_OBT_MSB:`BDC_OBT_LSB];
  wire [3:0] limit_scale_code   = r_lim[3:0];
  wire [1:0] sense_max_threshold = r_dth[`BDC_MIT_MSB:`BDC_MIT_LSB];
  wire [5:0] drain_threshold    = r_dth[5:0];
  wire       drain_q_mode       = r_dq[`BDC_VDQ_BIT];
  wire [5:0] drain_q_time       = r_dq[5:0];

  // Dither sweep
  reg  [23:0] dwell_cnt;
  reg  [3:0]  step_idx;
  reg  [23:0] dwell_lim;

  always @* begin
    case (dither_dwell_select)
      2'h0:    dwell_lim = DWELL_1MS;
      2'h1:    dwell_lim = DWELL_2MS;
      2'h2:    dwell_lim = DWELL_5MS;
      default: dwell_lim = DWELL_10MS;
    endcase
  end

  // A lowered nonzero step count takes effect at the next dwell end; a count of zero clears the index at once
  always @(posedge clk_sys) begin
    if (rst || dither_step_count == 4'h0) begin
      dwell_cnt <= 24'h000000;
      step_idx  <= 4'h0;
    end else if (dwell_cnt >= dwell_lim - 24'h000001) begin
      dwell_cnt <= 24'h000000;
      if (step_idx >= dither_step_count)
        step_idx <= 4'h0;
      else
        step_idx <= step_idx + 4'h1;
    end else begin
      dwell_cnt <= dwell_cnt + 24'h000001;
    end
  end

  wire [16:0] base_ns   = align_sel ? `BDC_PERIOD_EDG_NS : `BDC_PERIOD_CTR_NS;
  wire [16:0] step_ns   = ({14'h0, dither_step_size} + 17'd1) * `BDC_DITHER_LSB_NS;
  wire [16:0] shrink_ns = {13'h0, step_idx} * step_ns;
  wire [16:0] next_pwm_period_ns =
    base_ns + {11'h0, pwm_period_code} * `BDC_PERIOD_LSB_NS - shrink_ns;

  reg [7:0]  next_sense_gain_x10;
  reg [11:0] next_max_mv;

  always @* begin
    case (sense_gain_select)
      2'h0:    next_sense_gain_x10 = 8'h19;
      2'h1:    next_sense_gain_x10 = 8'h32;
      2'h2:    next_sense_gain_x10 = 8'h64;
      default: next_sense_gain_x10 = 8'hc8;
    endcase
    case (sense_max_threshold)
      2'h0:    next_max_mv = 12'h0c8;
      2'h1:    next_max_mv = 12'h064;
      2'h2:    next_max_mv = 12'h032;
      default: next_max_mv = 12'h019;
    endcase
  end

  wire [11:0] next_dead_time_ns = (dead_time_code < `BDC_DEAD_MIN_CODE) ? `BDC_DEAD_MIN_NS
                                : {6'h0, dead_time_code} * `BDC_DEAD_LSB_NS;
  wire [12:0] next_limit_blank_ns = (limit_blank_code < `BDC_BLANK_MIN_CD) ? `BDC_BLANK_MIN_NS
                                  : ({8'h0, limit_blank_code} + 13'd2) * `BDC_BLANK_LSB_NS;
  wire [11:0] next_limit_mv16 = next_max_mv * ({8'h0, limit_scale_code} + 12'd1);

  always @(posedge clk_sys) begin
    if (rst) begin
      pwm_period_ns        <= 17'h00000;
      pwm_alignment_select <= 1'b0;
      dither_active        <= 1'b0;
      dither_step_index    <= 4'h0;
      sense_gain_x10       <= 8'h00;
      dead_time_ns         <= 12'h000;
      turn_on_ma_first     <= 7'h00;
      turn_on_ma_second    <= 7'h00;
      turn_off_ma_first    <= 7'h00;
      turn_off_ma_second   <= 7'h00;
      switch_mode          <= 4'h0;
      turn_on_slew_ns      <= 10'h000;
      turn_off_slew_ns     <= 10'h000;
      limit_blank_ns       <= 13'h0000;
      limit_threshold_mv16 <= 12'h000;
      drain_fault_mv       <= 12'h000;
      drain_qualifier_mode <= 1'b0;
      drain_qualify_ns     <= 12'h000;
    end else begin
      pwm_period_ns        <= next_pwm_period_ns;
      pwm_alignment_select <= align_sel;
      dither_active        <= (dither_step_count != 4'h0);
      dither_step_index    <= step_idx;
      sense_gain_x10       <= next_sense_gain_x10;
      dead_time_ns         <= next_dead_time_ns;
      turn_on_ma_first     <= {3'h0, on_first} * `BDC_CURR_LSB_MA;
      turn_on_ma_second    <= {3'h0, on_second} * `BDC_CURR_LSB_MA;
      turn_off_ma_first    <= {3'h0, off_first} * `BDC_CURR_LSB_MA;
      turn_off_ma_second   <= {3'h0, off_second} * `BDC_CURR_LSB_MA;
      // Bits: on first, on second, off first, off second
      switch_mode          <= {on_first == 4'h0, on_second == 4'h0,
                               off_first == 4'h0, off_second == 4'h0};
      turn_on_slew_ns      <= {6'h0, on_slew} * `BDC_SLEW_LSB_NS;
      turn_off_slew_ns     <= {6'h0, off_slew} * `BDC_SLEW_LSB_NS;
      limit_blank_ns       <= next_limit_blank_ns;
      limit_threshold_mv16 <= next_limit_mv16;
      drain_fault_mv       <= {6'h0, drain_threshold} * `BDC_DRAIN_LSB_MV;
      drain_qualifier_mode <= drain_q_mode;
      // Zero is passed through; short times are the host's concern
      drain_qualify_ns     <= {6'h0, drain_q_time} * `BDC_QUAL_LSB_NS;
    end
  end

endmodule // bdc_config_bank

/* File: hw/bdc_defs.vh */
/*
  Constants for the bridge drive configuration bank: serial frame layout,
  register addresses, reset values, field positions and timing figures.
  Assumes a 100 MHz system clock.
*/
`ifndef BDC_DEFS_VH
`define BDC_DEFS_VH

`define BDC_CLK_NS        10
`define BDC_MS_NS         1000000

`define BDC_FRAME_BITS    5'h10
`define BDC_ADDR_MSB      15
`define BDC_ADDR_LSB      11
`define BDC_WR_BIT        10
`define BDC_DATA_MSB      9
`define BDC_DATA_LSB      1
`define BDC_ADDR_LAST     5'h0a

`define BDC_ADDR_PWM_BASE 0
`define BDC_ADDR_DITHER   1
`define BDC_ADDR_BRIDGE   2
`define BDC_ADDR_TURN_ON  3
`define BDC_ADDR_TURN_OFF 4
`define BDC_ADDR_SLEW     5
`define BDC_ADDR_LIMIT    6
`define BDC_ADDR_DRAIN_TH 7
`define BDC_ADDR_DRAIN_Q  8

`define BDC_RST_PWM_BASE  9'h026
`define BDC_RST_BRIDGE    9'h020
`define BDC_RST_LIMIT     9'h07f
`define BDC_RST_DRAIN_TH  9'h01f
`define BDC_RST_DRAIN_Q   9'h03f
`define BDC_RST_ZERO      9'h000

`define BDC_ALIGN_BIT     6
`define BDC_DP_MSB        8
`define BDC_DP_LSB        6
`define BDC_DD_MSB        5
`define BDC_DD_LSB        4
`define BDC_SA_MSB        7
`define BDC_SA_LSB        6
`define BDC_HI4_MSB       7
`define BDC_HI4_LSB       4
`define BDC_OBT_MSB       8
`define BDC_OBT_LSB       4
`define BDC_MIT_MSB       8
`define BDC_MIT_LSB       7
`define BDC_VDQ_BIT       7

`define BDC_PERIOD_CTR_NS 17'd20100
`define BDC_PERIOD_EDG_NS 17'd20050
`define BDC_PERIOD_LSB_NS 17'd800
`define BDC_DITHER_LSB_NS 17'd200
`define BDC_DEAD_LSB_NS   12'd50
`define BDC_DEAD_MIN_NS   12'd100
`define BDC_DEAD_MIN_CODE 6'd3
`define BDC_SLEW_LSB_NS   10'd50
`define BDC_BLANK_LSB_NS  13'd200
`define BDC_BLANK_MIN_NS  13'd1000
`define BDC_BLANK_MIN_CD  5'd4
`define BDC_CURR_LSB_MA   7'd5
`define BDC_DRAIN_LSB_MV  12'd50
`define BDC_QUAL_LSB_NS   12'd50

`endif
